// file: logic/ucs_ctrl.sv
// Purpose: Host controller that brings up, configures and runs a UART
// Assumes: device register bus on ref_clk; software drives the host port
// Notes:   How it works
// How it works
// RL1: device applies immediate registers at once
// RL2: synchronous fields act only after transfer
// RL3: hold bit cleared; transfers only then
// RL4: wait for transfer flag zero first
// RL5: write one to flag after configuring
// RL6: edit static fields only while idle
// RL7: clear core clock gates before static edits
// RL8: set gates again after static edits
// RL9: wake threshold is ten static bits
// RL10: flow, escape and filter fields eight bits
// RL11: gap fields sixteen bits, idle ten
// RL12: all other writable registers are immediate
// RL13: clocks on, resets pulsed, hold cleared
// RL14: poll, static, clock, baud, frame, trigger
// RL15: watermark, mask, fill, clear, enable, wait
// RL16: data port write pushes, read pops
// RL17: rx watermark, enable, wait, read count
// RL18: device copies synchronous set coherently
// RL19: device ignores trigger during transfer
`default_nettype none
module ucs_ctrl (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire ucs_pkg::ucs_addr_t h_addr,
    input wire ucs_pkg::ucs_word_t h_wdata,
    input wire logic h_wr,
    input wire logic h_rd,
    output ucs_pkg::ucs_word_t h_rdata,
    output logic irq,
    output ucs_pkg::ucs_addr_t dev_paddr,
    output logic dev_psel,
    output logic dev_penable,
    output logic dev_pwrite,
    output ucs_pkg::ucs_word_t dev_pwdata,
    input wire ucs_pkg::ucs_word_t dev_prdata,
    input wire logic dev_pready,
    output logic peripheral_reset,
    output logic bus_clock_gate,
    output logic mem_clk_en
);
    import ucs_pkg::*;
    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        ucs_seq_e st; // Sequencer phase
        ucs_step_t step; // Current program step
        logic [1:0] grp; // Running command group
        logic req; // Bus request pulse
        logic [2:0] pins; // {ram clock, bus gate, peripheral reset}
        logic [NEVT-1:0] evt; // Sticky done events
        logic [NEVT-1:0] mask; // Event enables
        logic irq; // Registered interrupt level
        ucs_word_t rdata; // Host read data
        logic [NCFG-1:0][DATA_W-1:0] cfg; // Words to load into the device
        logic [7:0] rx_byte; // Last byte popped
        logic [7:0] rx_cnt; // Fill count seen before the pop
        logic gates_off; // Core clocks last written off
        logic ena_tx; // Low-watermark enable last written
    } ucs_ctl_s;
    ucs_ctl_s q, d;
    ucs_op_e op_kind; // Current step decoded
    ucs_addr_t op_addr;
    ucs_word_t op_data;
    logic op_last;
    logic apb_done;
    ucs_word_t apb_rdata;

    // ****************************************************************
    // Program table
    // ****************************************************************
    // Step decode; polls use op_data as the bit to watch
    always_comb begin
        op_kind = OP_WR;
        op_addr = DEV_SYNC;
        op_data = '0;
        op_last = 1'b0;
        case (q.step)
            6'h00, 6'h03: begin // Clocks on, peripheral reset held
                op_kind = OP_PIN; // RL13
                op_data = ucs_word_t'(PINS_ON_RST);
            end
            6'h01, 6'h04: begin // Peripheral reset released
                op_kind = OP_PIN; // RL13
                op_data = ucs_word_t'(PINS_ON_RUN);
            end
            6'h02: begin // Core reset set around the reset pulse
                op_addr = DEV_CLKCONF;
                op_data = q.cfg[CFG_CLKCONF] | CC_CORE_RST; // RL13
            end
            6'h05, 6'h08: begin // Core reset off, core clocks gated
                op_addr = DEV_CLKCONF;
                op_data = q.cfg[CFG_CLKCONF]; // RL7
            end
            STEP_HOLD: begin // Hold bit cleared so transfers may run
                op_data = '0; // RL3
                op_last = 1'b1;
            end
            STEP_CFG: begin // Last transfer must be finished
                op_kind = OP_POLL0; // RL4
                op_data = SYNC_UPD;
            end
            6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h0f, 6'h10, 6'h11: begin
                op_addr = CFG_DEV_ADDR[4'(q.step - STEP_STATIC_OFF)]; // RL6
                op_data = q.cfg[4'(q.step - STEP_STATIC_OFF)];
            end
            STEP_OPEN: begin // Clock source, divider, gates back on
                op_addr = DEV_CLKCONF;
                op_data = q.cfg[CFG_CLKCONF] | CC_GATES; // RL8
            end
            STEP_BAUD: begin
                op_addr = DEV_CLKDIV; // RL14
                op_data = q.cfg[CFG_BAUD];
            end
            6'h14: begin // Data length and parity
                op_addr = DEV_CONF0; // RL14
                op_data = q.cfg[CFG_FRAME];
            end
            STEP_UPD: begin // Copy the synchronous set into the core
                op_data = SYNC_UPD; // RL5
                op_last = 1'b1;
            end
            STEP_TX, STEP_RX: begin
                op_addr = CFG_DEV_ADDR[CFG_WMARK];
                op_data = q.cfg[CFG_WMARK];
            end
            6'h17: begin // Low-watermark interrupt off while filling
                op_addr = DEV_INT_ENA; // RL15
            end
            6'h18: begin // One byte pushed into the transmit FIFO
                op_addr = DEV_FIFO; // RL16
                op_data = q.cfg[CFG_TXBYTE];
            end
            6'h19: begin
                op_addr = DEV_INT_CLR; // RL15
                op_data = INT_TX_LOW;
            end
            6'h1a: begin
                op_addr = DEV_INT_ENA; // RL15
                op_data = INT_TX_LOW;
            end
            STEP_TX_LAST: begin // Drained below the watermark
                op_kind = OP_POLL1; // RL15
                op_addr = DEV_INT_RAW;
                op_data = INT_TX_LOW;
                op_last = 1'b1;
            end
            6'h1d: begin
                op_addr = DEV_INT_ENA; // RL17
                op_data = INT_RX_HIGH;
            end
            6'h1e: begin
                op_kind = OP_POLL1; // RL17
                op_addr = DEV_INT_RAW;
                op_data = INT_RX_HIGH;
            end
            STEP_RX_CNT: begin
                op_kind = OP_RD; // RL17
                op_addr = DEV_STATUS;
            end
            STEP_RX_LAST: begin // Pop one received byte
                op_kind = OP_RD; // RL16
                op_addr = DEV_FIFO;
                op_last = 1'b1;
            end
            default: op_last = 1'b1; // Unused steps end the run
        endcase
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    // Host port, sequencer and shadow tracking in one place
    always_comb begin
        logic adv;
        logic miss;
        adv = 1'b0;
        miss = 1'b0;
        d = q;
        d.req = 1'b0;
        d.rdata = '0;
        // Host writes; a command while busy is dropped
        if (h_wr) begin
            if (h_addr == H_CMD && q.st == ST_IDLE) begin
                if (h_wdata[EVT_INIT]) begin
                    d.grp = 2'(EVT_INIT);
                    d.step = STEP_INIT;
                    d.st = ST_ISSUE;
                end else if (h_wdata[EVT_CFG]) begin
                    d.grp = 2'(EVT_CFG);
                    d.step = STEP_CFG;
                    d.st = ST_ISSUE;
                end else if (h_wdata[EVT_TX]) begin
                    d.grp = 2'(EVT_TX);
                    d.step = STEP_TX;
                    d.st = ST_ISSUE;
                end else if (h_wdata[EVT_RX]) begin
                    d.grp = 2'(EVT_RX);
                    d.step = STEP_RX;
                    d.st = ST_ISSUE;
                end
            end
            if (h_addr == H_EVT) begin // Write one to clear
                d.evt = q.evt & ~h_wdata[NEVT-1:0];
            end
            if (h_addr == H_MASK) begin
                d.mask = h_wdata[NEVT-1:0];
            end
            for (int k = 0; k < NCFG; k++) begin // Masks keep field widths
                if (h_addr == H_CFG_BASE + WORD_BYTES * 8'(k)) begin
                    d.cfg[k] = h_wdata & CFG_MASK[k]; // RL9 RL10 RL11
                end
            end
        end
        // Host reads, data valid the cycle after the strobe
        if (h_rd) begin
            case (h_addr)
                H_STATUS: d.rdata = ucs_word_t'({q.step, q.grp, q.st != ST_IDLE});
                H_EVT: d.rdata = ucs_word_t'(q.evt);
                H_MASK: d.rdata = ucs_word_t'(q.mask);
                H_RXD: d.rdata = ucs_word_t'({q.rx_cnt, q.rx_byte});
                default: begin
                    for (int k = 0; k < NCFG; k++) begin
                        if (h_addr == H_CFG_BASE + WORD_BYTES * 8'(k)) begin
                            d.rdata = q.cfg[k];
                        end
                    end
                end
            endcase
        end
        // Sequencer
        case (q.st)
            ST_IDLE: ;
            ST_ISSUE: begin
                if (op_kind == OP_PIN) begin // Pins change at once
                    d.pins = 3'(op_data);
                    adv = 1'b1;
                end else begin
                    d.req = 1'b1;
                    d.st = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (apb_done) begin
                    miss = (op_kind == OP_POLL0 && (apb_rdata & op_data) != '0) ||
                        (op_kind == OP_POLL1 && (apb_rdata & op_data) == '0);
                    if (miss) begin // Poll again, same step
                        d.st = ST_ISSUE; // RL4
                    end else begin
                        if (op_kind == OP_RD && q.step == STEP_RX_CNT) begin
                            d.rx_cnt = 8'(apb_rdata); // RL17
                        end else if (op_kind == OP_RD) begin
                            d.rx_byte = 8'(apb_rdata);
                        end
                        adv = 1'b1;
                    end
                end
            end
            default: d.st = ST_IDLE;
        endcase
        if (adv) begin // Next step or end of run
            if (op_last) begin
                d.st = ST_IDLE;
                d.evt[q.grp] = 1'b1; // Set after clear: set wins
            end else begin
                d.step = q.step + 6'h01;
                d.st = ST_ISSUE;
            end
        end
        // Shadows of what the device was last told
        if (dev_psel && !dev_penable && dev_pwrite) begin
            if (dev_paddr == DEV_CLKCONF) begin
                d.gates_off = (dev_pwdata & CC_GATES) == '0;
            end
            if (dev_paddr == DEV_INT_ENA) begin
                d.ena_tx = (dev_pwdata & INT_TX_LOW) != '0;
            end
        end
        d.irq = (d.evt & d.mask) != '0; // Level, registered on the same edge as the events
    end

    // State register; ce low freezes everything
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '{st: ST_IDLE, pins: PINS_RESET, default: '0};
        end else if (ce) begin
            q <= d;
        end
    end

    // ****************************************************************
    // Device bus master
    // ****************************************************************
    ucs_apb_mst u_apb (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .ce(ce),
        .req(q.req),
        .req_wr(op_kind == OP_WR),
        .req_addr(op_addr),
        .req_wdata(op_data),
        .done(apb_done),
        .rdata(apb_rdata),
        .paddr(dev_paddr),
        .psel(dev_psel),
        .penable(dev_penable),
        .pwrite(dev_pwrite),
        .pwdata(dev_pwdata),
        .prdata(dev_prdata),
        .pready(dev_pready)
    );

    assign h_rdata = q.rdata;
    assign irq = q.irq;
    assign mem_clk_en = q.pins[2];
    assign bus_clock_gate = q.pins[1];
    assign peripheral_reset = q.pins[0];

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    sequence s_wr(ucs_addr_t a);
        dev_psel && !dev_penable && dev_pwrite && dev_paddr == a;
    endsequence
    sequence s_rx_done;
        ce && q.st == ST_WAIT && q.step == STEP_RX_LAST && apb_done;
    endsequence
    a_hold_clear: assert property (s_wr(DEV_SYNC) |-> (dev_pwdata & SYNC_HOLD) == '0) // RL3
        else $error("hold bit written as one");
    a_upd_wait: assert property (ce && q.st == ST_WAIT && q.step == STEP_CFG && apb_done && // RL4
        (apb_rdata & SYNC_UPD) != '0 |=> q.st == ST_ISSUE && q.step == STEP_CFG)
        else $error("config went on while transfer busy");
    a_upd_last: assert property (s_wr(DEV_SYNC) && (dev_pwdata & SYNC_UPD) != '0 |-> // RL5
        q.step == STEP_UPD)
        else $error("transfer triggered out of order");
    a_static_gated: assert property (dev_psel && !dev_penable && dev_pwrite && // RL6
        q.step > STEP_CFG + 6'h01 && q.step < STEP_OPEN |-> q.gates_off)
        else $error("static field written with core clock on");
    a_gates_on: assert property (s_wr(DEV_CLKCONF) && q.step == STEP_OPEN |-> // RL8
        (dev_pwdata & CC_GATES) == CC_GATES)
        else $error("core clocks not restarted");
    a_init_order: assert property ($fell(peripheral_reset) |-> bus_clock_gate && mem_clk_en) // RL13
        else $error("reset released before clocks");
    a_baud_order: assert property (s_wr(DEV_CLKDIV) |-> q.step == STEP_BAUD && !q.gates_off) // RL14
        else $error("baud written out of order");
    a_tx_fill: assert property (s_wr(DEV_FIFO) |-> !q.ena_tx) // RL15
        else $error("FIFO filled with low interrupt enabled");
    a_rx_capture: assert property (s_rx_done |=> q.evt[EVT_RX] && // RL17
        q.rx_byte == 8'($past(apb_rdata)))
        else $error("received byte not captured");
    a_bus_phase: assert property (dev_psel && !dev_penable && ce |=> dev_psel && dev_penable)
        else $error("access phase missing");
endmodule
`default_nettype wire

// file: logic/ucs_pkg.sv
// Purpose: Shared constants and types of the UART bring-up controller
// Assumes: device register bus runs on ref_clk, addresses are byte offsets
// Notes:   device field layouts below are fixed by this controller
`default_nettype none
package ucs_pkg;
    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NCFG = 14; // Configuration words kept for the device
    localparam int NEVT = 4; // Sticky events, one per command group
    localparam logic [ADDR_W-1:0] WORD_BYTES = 8'h04;
    typedef logic [DATA_W-1:0] ucs_word_t;
    typedef logic [ADDR_W-1:0] ucs_addr_t;
    typedef logic [5:0] ucs_step_t;
    // ****************************************************************
    // Device register offsets
    // ****************************************************************
    localparam ucs_addr_t DEV_FIFO = 8'h00;
    localparam ucs_addr_t DEV_INT_RAW = 8'h04;
    localparam ucs_addr_t DEV_INT_ENA = 8'h0c;
    localparam ucs_addr_t DEV_INT_CLR = 8'h10;
    localparam ucs_addr_t DEV_CLKDIV = 8'h14;
    localparam ucs_addr_t DEV_STATUS = 8'h1c;
    localparam ucs_addr_t DEV_CONF0 = 8'h20;
    localparam ucs_addr_t DEV_CLKCONF = 8'h78;
    localparam ucs_addr_t DEV_SYNC = 8'h80;
    // Device address of each configuration word, entry 0 in the low byte
    localparam logic [NCFG-1:0][ADDR_W-1:0] CFG_DEV_ADDR = {
        8'h00, 8'h60, 8'h5c, 8'h58, 8'h54, 8'h50, 8'h48,
        8'h40, 8'h3c, 8'h38, 8'h18, 8'h78, 8'h20, 8'h14};
    // Writable bits of each word: sets every field width
    localparam logic [NCFG-1:0][DATA_W-1:0] CFG_MASK = {
        32'h0000_00ff, 32'h0000_ffff, 32'h0000_ffff, 32'h0000_ffff,
        32'h0000_ffff, 32'h0000_ffff, 32'h0000_03ff, 32'h0000_00ff,
        32'h0000_00ff, 32'h0000_03ff, 32'h0000_01ff, 32'h0000_03ff,
        32'h0000_000f, 32'h000f_0fff};
    localparam logic [3:0] CFG_CLKCONF = 4'h2;
    localparam logic [3:0] CFG_BAUD = 4'h0;
    localparam logic [3:0] CFG_FRAME = 4'h1;
    localparam logic [3:0] CFG_WMARK = 4'hc;
    localparam logic [3:0] CFG_TXBYTE = 4'hd;
    // ****************************************************************
    // Device field values
    // ****************************************************************
    localparam ucs_word_t CC_TX_GATE = 32'h0000_1000;
    localparam ucs_word_t CC_RX_GATE = 32'h0000_2000;
    localparam ucs_word_t CC_GATES = CC_TX_GATE | CC_RX_GATE;
    localparam ucs_word_t CC_CORE_RST = 32'h0000_4000;
    localparam ucs_word_t SYNC_UPD = 32'h0000_0001;
    localparam ucs_word_t SYNC_HOLD = 32'h0000_0002;
    localparam ucs_word_t INT_RX_HIGH = 32'h0000_0001;
    localparam ucs_word_t INT_TX_LOW = 32'h0000_0002;
    // ****************************************************************
    // Host register offsets and bits
    // ****************************************************************
    localparam ucs_addr_t H_CMD = 8'h00;
    localparam ucs_addr_t H_STATUS = 8'h04;
    localparam ucs_addr_t H_EVT = 8'h08;
    localparam ucs_addr_t H_MASK = 8'h0c;
    localparam ucs_addr_t H_RXD = 8'h10;
    localparam ucs_addr_t H_CFG_BASE = 8'h40;
    localparam int EVT_INIT = 0;
    localparam int EVT_CFG = 1;
    localparam int EVT_TX = 2;
    localparam int EVT_RX = 3;
    // Pin pattern {ram clock, bus clock gate, peripheral reset}
    localparam logic [2:0] PINS_RESET = 3'h1;
    localparam logic [2:0] PINS_ON_RST = 3'h7;
    localparam logic [2:0] PINS_ON_RUN = 3'h6;
    // ****************************************************************
    // Program steps
    // ****************************************************************
    localparam ucs_step_t STEP_INIT = 6'h00;
    localparam ucs_step_t STEP_HOLD = 6'h06;
    localparam ucs_step_t STEP_CFG = 6'h07;
    localparam ucs_step_t STEP_STATIC_OFF = 6'h06;
    localparam ucs_step_t STEP_OPEN = 6'h12;
    localparam ucs_step_t STEP_BAUD = 6'h13;
    localparam ucs_step_t STEP_UPD = 6'h15;
    localparam ucs_step_t STEP_TX = 6'h16;
    localparam ucs_step_t STEP_TX_LAST = 6'h1b;
    localparam ucs_step_t STEP_RX = 6'h1c;
    localparam ucs_step_t STEP_RX_CNT = 6'h1f;
    localparam ucs_step_t STEP_RX_LAST = 6'h20;
    typedef enum logic [2:0] {OP_PIN, OP_WR, OP_RD, OP_POLL0, OP_POLL1} ucs_op_e;
    typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} ucs_seq_e;
    typedef enum logic [1:0] {AP_IDLE, AP_SETUP, AP_ACCESS} ucs_apb_e;
endpackage
`default_nettype wire

// file: logic/ucs_apb_mst.sv
// Purpose: One-transfer register bus master toward the UART device
// Assumes: device bus clock is ref_clk; pready comes from that clock
// Notes:   a request is taken only while idle
`default_nettype none
module ucs_apb_mst (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic req,
    input wire logic req_wr,
    input wire ucs_pkg::ucs_addr_t req_addr,
    input wire ucs_pkg::ucs_word_t req_wdata,
    output logic done,
    output ucs_pkg::ucs_word_t rdata,
    output ucs_pkg::ucs_addr_t paddr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output ucs_pkg::ucs_word_t pwdata,
    input wire ucs_pkg::ucs_word_t prdata,
    input wire logic pready
);
    import ucs_pkg::*;
    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        ucs_apb_e st;
        logic psel;
        logic penable;
        logic pwrite;
        ucs_addr_t paddr;
        ucs_word_t pwdata;
        ucs_word_t rdata;
        logic done;
    } ucs_apb_s;
    ucs_apb_s q, d;

    // Phase sequencing: setup, access, hold until pready
    always_comb begin
        d = q;
        d.done = 1'b0;
        case (q.st)
            AP_IDLE: begin
                if (req) begin // Latch command, enter setup
                    d.st = AP_SETUP;
                    d.psel = 1'b1;
                    d.pwrite = req_wr;
                    d.paddr = req_addr;
                    d.pwdata = req_wdata;
                end
            end
            AP_SETUP: begin
                d.st = AP_ACCESS;
                d.penable = 1'b1;
            end
            AP_ACCESS: begin
                if (pready) begin // Slave done, capture read data
                    d.st = AP_IDLE;
                    d.psel = 1'b0;
                    d.penable = 1'b0;
                    d.rdata = prdata;
                    d.done = 1'b1;
                end
            end
            default: d.st = AP_IDLE;
        endcase
    end

    // Register; ce low freezes the bus mid-phase
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '{st: AP_IDLE, default: '0};
        end else if (ce) begin
            q <= d;
        end
    end

    assign done = q.done;
    assign rdata = q.rdata;
    assign paddr = q.paddr;
    assign psel = q.psel;
    assign penable = q.penable;
    assign pwrite = q.pwrite;
    assign pwdata = q.pwdata;
endmodule
`default_nettype wire

// file: sim/ucs_dev_model.sv
// Purpose: Behavioural UART device on the controller's register bus
// Assumes: one clock; ready comes at once or one cycle late
// Notes:   update flag stays busy sixty-three cycles after a trigger,
//          long enough for a second configuration to find it busy
`default_nettype none
module ucs_dev_model (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire ucs_pkg::ucs_addr_t dev_paddr,
    input wire logic dev_psel,
    input wire logic dev_penable,
    input wire logic dev_pwrite,
    input wire ucs_pkg::ucs_word_t dev_pwdata,
    output ucs_pkg::ucs_word_t dev_prdata,
    output logic dev_pready
);
    timeunit 1ns;
    timeprecision 1ps;
    import ucs_pkg::*;
    // ********
    // Registers
    // ********
    ucs_word_t regs [0:63]; // Bus side words
    ucs_word_t core_baud; // Core copy of the divisor
    ucs_word_t rdv; // Read value
    logic [5:0] upd_cnt; // Transfer time left
    logic [31:0] cyc; // Changing pattern off the bus
    wire go = dev_psel & dev_penable & dev_pready;
    // Odd cycles answer at once, even ones stall the master
    assign dev_pready = dev_penable & cyc[0];
    assign rdv = (dev_paddr == DEV_FIFO) ? 32'h0000_00a5 :
        (dev_paddr == DEV_STATUS) ? 32'h0000_0005 :
        (dev_paddr == DEV_SYNC) ? {31'h0, upd_cnt != 6'h00} : regs[dev_paddr[7:2]];
    // Released bus never shows stale data
    assign dev_prdata = go ? rdv : ~cyc;
    // Writes, transfer timer and interrupt sources
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cyc <= '0;
            upd_cnt <= '0;
            core_baud <= '0;
            for (int i = 0; i < 64; i++) regs[i] <= '0;
        end else begin
            cyc <= cyc + 1;
            if (upd_cnt != 6'h00) upd_cnt <= upd_cnt - 6'h01;
            if (upd_cnt == 6'h01) core_baud <= regs[5];
            if (go && dev_pwrite) begin
                regs[dev_paddr[7:2]] <= dev_pwdata;
                if (dev_paddr == DEV_SYNC && dev_pwdata[0] && !regs[32][1] && upd_cnt == 6'h00) begin
                    upd_cnt <= 6'h3f;
                end
                if (dev_paddr == DEV_INT_ENA) regs[1] <= regs[1] | dev_pwdata;
                if (dev_paddr == DEV_INT_CLR) regs[1] <= regs[1] & ~dev_pwdata;
            end
        end
    end
endmodule
`default_nettype wire

// file: sim/test_ucs_ctrl.sv
// Purpose: Self-checking bench of the bring-up controller
// Assumes: host port strobes are one cycle, read data one cycle later
// Notes:   clock enable is dropped once to show the host port freezes
`default_nettype none
module test_ucs_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    import ucs_pkg::*;
    logic ref_clk = 0, rst_b = 0, h_wr = 0, h_rd = 0, irq, dev_psel, dev_penable, dev_pwrite, dev_pready;
    logic peripheral_reset, bus_clock_gate, mem_clk_en, ce = 1;
    ucs_addr_t h_addr = '0, dev_paddr;
    ucs_word_t h_wdata = '0, h_rdata, dev_pwdata, dev_prdata, v;
    int errors = 0, comparisons = 0, cycles = 0;
    always #20 ref_clk = ~ref_clk;
    ucs_ctrl i_dut (.ref_clk, .rst_b, .ce, .h_addr, .h_wdata, .h_wr, .h_rd, .h_rdata, .irq, .dev_paddr,
        .dev_psel, .dev_penable, .dev_pwrite, .dev_pwdata, .dev_prdata, .dev_pready, .peripheral_reset,
        .bus_clock_gate, .mem_clk_en);
    ucs_dev_model i_dev (.ref_clk, .rst_b, .dev_paddr, .dev_psel, .dev_penable, .dev_pwrite, .dev_pwdata,
        .dev_prdata, .dev_pready);
    // ********
    // Tasks
    // ********
    task automatic check(input ucs_word_t seen, input ucs_word_t exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input ucs_addr_t a, input ucs_word_t d);
        @(posedge ref_clk);
        h_wr <= 1'b1;
        h_addr <= a;
        h_wdata <= d;
        @(posedge ref_clk);
        h_wr <= 1'b0;
    endtask
    task automatic rd(input ucs_addr_t a, output ucs_word_t d);
        @(posedge ref_clk);
        h_rd <= 1'b1;
        h_addr <= a;
        @(posedge ref_clk);
        h_rd <= 1'b0;
        #1 d = h_rdata;
    endtask
    // Bounded poll of one sticky event
    task automatic wait_evt(input int b);
        ucs_word_t e = '0;
        for (int i = 0; i < 400 && e[b] !== 1'b1; i++) rd(H_EVT, e);
        check(e[b], 1'b1, "event");
        $display("test %0d done", b);
    endtask
    task automatic results();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            results();
        end
    end
    // Main sequence
    initial begin
        repeat (3) @(posedge ref_clk);
        check({mem_clk_en, bus_clock_gate, peripheral_reset}, PINS_RESET, "reset pins");
        rst_b <= 1'b1;
        for (int k = 0; k < NCFG; k++) wr(ucs_addr_t'(H_CFG_BASE + WORD_BYTES * k), '1);
        for (int k = 0; k < NCFG; k++) begin
            rd(ucs_addr_t'(H_CFG_BASE + WORD_BYTES * k), v);
            check(v, CFG_MASK[k], "config word");
        end
        rd(8'h30, v);
        check(v, '0, "unmapped");
        wr(H_MASK, 32'hf);
        wr(H_CMD, 32'h1);
        wr(H_CMD, 32'h2);
        wait_evt(EVT_INIT);
        check({mem_clk_en, bus_clock_gate, peripheral_reset}, PINS_ON_RUN, "run pins");
        check(i_dev.regs[32], '0, "hold bit");
        rd(H_STATUS, v);
        check(v[0], 1'b0, "busy refused");
        check(irq, 1'b1, "irq");
        wr(H_CMD, 32'h2);
        wait_evt(EVT_CFG);
        check(i_dev.regs[30], CFG_MASK[CFG_CLKCONF] | CC_GATES, "gates");
        check(i_dev.regs[8], CFG_MASK[CFG_FRAME], "frame");
        // Second configuration finds the transfer still busy and must poll
        wr(H_EVT, 32'h2);
        wr(H_CMD, 32'h2);
        wait_evt(EVT_CFG);
        wr(H_CMD, 32'h4);
        wait_evt(EVT_TX);
        check(i_dev.core_baud, CFG_MASK[CFG_BAUD], "core baud");
        check(i_dev.regs[0], CFG_MASK[CFG_TXBYTE], "tx byte");
        wr(H_CMD, 32'h8);
        wait_evt(EVT_RX);
        rd(H_RXD, v);
        check(v, 32'h0000_05a5, "rx data");
        wr(H_EVT, 32'hf);
        wr(H_MASK, 32'h0);
        rd(H_EVT, v);
        check(v, '0, "events cleared");
        check(irq, 1'b0, "irq low");
        // Clock enable low: the strobe is lost
        ce <= 1'b0;
        wr(H_MASK, 32'hf);
        ce <= 1'b1;
        rd(H_MASK, v);
        check(v, '0, "ce freeze");
        results();
    end
endmodule
`default_nettype wire
